/* File: redriver_pkg.sv */
// constants, register map and state type for the redriver lane control
package redriver_pkg;

   localparam int CLK_PERIOD_NS = 4;

   localparam int IDLE_ENTRY_NS  = 10;
   localparam int IDLE_ENTRY_CYC = (IDLE_ENTRY_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
   localparam int U1_EXIT_NS     = 6;
   localparam int U1_EXIT_CYC    = (U1_EXIT_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
   localparam int U23_EXIT_US    = 10;
   localparam int U23_EXIT_CYC   = (U23_EXIT_US * 1000 + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
   localparam int RXDET_INTVL_MS = 12;
   localparam int RXDET_CYC_DEF  = RXDET_INTVL_MS * 1000000 / CLK_PERIOD_NS;
   localparam int SHTDN_EXIT_MS  = 1;
   localparam int SHTDN_CYC_DEF  = SHTDN_EXIT_MS * 1000000 / CLK_PERIOD_NS;
   localparam int PWRUP_ACT_MS   = 1;
   localparam int PWRUP_CYC_DEF  = PWRUP_ACT_MS * 1000000 / CLK_PERIOD_NS;
   localparam int HOLD_CYC_DEF   = 16;
   localparam int U1_U2_CYC_DEF  = 1024;

   localparam int TIMER_W = 24;
   localparam int EXIT_W  = 12;

   localparam logic [7:0] REG_LINK_SNOOP = 8'h12;
   localparam logic [7:0] REG_SNOOP_CTRL = 8'h13;
   localparam int LANE_LSB      = 0;
   localparam int PWR_LSB       = 5;
   localparam int SNOOP_DIS_BIT = 0;
   localparam int SNOOP_ACT_BIT = 1;
   localparam int LINK_ST_LSB   = 2;
   localparam logic [4:0] LANE_RST      = 5'h00;
   localparam logic [2:0] PWR_RST       = 3'h0;
   localparam logic       SNOOP_DIS_RST = 1'b0;

   localparam logic [19:0] AUX_LANE_ADDR = 20'h00101;
   localparam logic [19:0] AUX_PWR_ADDR  = 20'h00600;
   localparam logic [2:0]  PWR_D3        = 3'h2;

   localparam int NUM_STRAPS = 7;
   localparam int ST_IFSEL   = 0;
   localparam int ST_UA0     = 1;
   localparam int ST_UA1     = 2;
   localparam int ST_UB0     = 3;
   localparam int ST_UB1     = 4;
   localparam int ST_V0      = 5;
   localparam int ST_V1      = 6;
   localparam logic [1:0] STRAP_PIN_MODE = 2'h0;
   localparam int SYNC_W = 7 + 3 * NUM_STRAPS;

   typedef enum logic [2:0] {st_shut, st_disc, st_u0, st_u1, st_u23} link_state_t;

endpackage

/* File: typec_redriver_lane_control.sv */
// link power tracking, equalizer gating, aux snoop lane control and strap capture
`timescale 1ns/1ps
`default_nettype none

// Functional notes
// - leaving U0, output goes electrically idle after about 10 ns
// - idle break in U1 starts LFPS forwarding after about 6 ns
// - idle break in U2/U3 starts LFPS forwarding after about 10 us
// - while disconnected, receiver detection repeats at most every 12 ms
// - control pin zero raised: leave shutdown, reach U2/U3 after 1 ms
// - device becomes active within 1 ms of supply good
// - track U0, U1, U2, U3 from line conditions only
// - equalization is off while LFPS is present
// - without LFPS, equalize with strap or register gain
// - after power-up, run receiver detection periodically
// - receiver found: enable own termination, ready to redrive
// - in DP mode watch AUX writes to lane count and power state
// - active DP lanes follow the snooped lane count
// - snooped power state D3 turns all DP lanes off
// - snoop on after reset; snoop disable hands lanes to configuration
// - snoop only in register mode; pin mode enables four lanes on hot plug
// - snooped fields live at 0x12, snoop disable at 0x13
// - each strap resolves four levels: low, pull-down, float, high
// - straps latched when internal reset ends; pulls released after hold
// - two straps per path give sixteen gains; registers may override
// - interface strap level zero means pin mode, otherwise register mode
// - power-up in USB-only mode; pin zero low-high-low leaves it
module typec_redriver_lane_control
   import redriver_pkg::*;
#(
   parameter int unsigned RXDET_CYC = RXDET_CYC_DEF,
   parameter int unsigned SHTDN_CYC = SHTDN_CYC_DEF,
   parameter int unsigned PWRUP_CYC = PWRUP_CYC_DEF,
   parameter int unsigned HOLD_CYC  = HOLD_CYC_DEF,
   parameter int unsigned U1_U2_CYC = U1_U2_CYC_DEF
)(
   input  wire logic                    clock_i,
   input  wire logic                    rst_b_i,
   input  wire logic                    supply_ok_i,
   input  wire logic                    control_pin_zero_i,
   input  wire logic                    far_term_i,
   input  wire logic                    elec_idle_i,
   input  wire logic                    lfps_i,
   input  wire logic                    ss_rate_i,
   input  wire logic                    hot_plug_input_i,
   input  wire logic [3*NUM_STRAPS-1:0] strap_level_i,
   input  wire logic                    dp_mode_i,
   input  wire logic [3:0]              cfg_lane_en_i,
   input  wire logic [3:0]              gain_reg_a_i,
   input  wire logic [3:0]              gain_reg_b_i,
   input  wire logic [3:0]              gain_reg_video_i,
   input  wire logic                    aux_wr_i,
   input  wire logic [19:0]             aux_addr_i,
   input  wire logic [7:0]              aux_data_i,
   input  wire logic                    reg_wr_i,
   input  wire logic [7:0]              reg_addr_i,
   input  wire logic [7:0]              reg_wdata_i,
   output var  logic                    device_active_o,
   output var  logic                    strap_pull_en_o,
   output var  logic                    reg_mode_o,
   output var  logic                    usb_only_o,
   output var  link_state_t             link_state_o,
   output var  logic                    tx_idle_o,
   output var  logic                    lfps_fwd_o,
   output var  logic                    rx_detect_o,
   output var  logic                    rx_term_en_o,
   output var  logic                    eq_enable_o,
   output var  logic [3:0]              usb_path_a_gain_o,
   output var  logic [3:0]              usb_path_b_gain_o,
   output var  logic [3:0]              video_gain_o,
   output var  logic [3:0]              dp_lane_en_o,
   output var  logic [7:0]              reg_rdata_o
);

   default clocking cb @(posedge clock_i);
   endclocking
   default disable iff (!rst_b_i);

   localparam int A_U23 = U23_EXIT_CYC;

   logic [SYNC_W-1:0]       pin_meta;
   logic [SYNC_W-1:0]       pin_sync;
   logic [2*NUM_STRAPS-1:0] strap_dec;
   logic [2*NUM_STRAPS-1:0] strap_code;
   logic [TIMER_W-1:0]      pwr_cnt;
   logic [TIMER_W-1:0]      hold_cnt;
   logic [TIMER_W-1:0]      link_cnt;
   logic [EXIT_W-1:0]       exit_cnt;
   logic [1:0]              ctl_seq;
   logic                    snoop_dis;
   logic [4:0]              lane_cnt;
   logic [2:0]              pwr_state;
   logic [7:0]              next_rdata;

   ////////////////////////////////////////////////////////////////////////
   // pin synchronisers: every pin is asynchronous to clock_i

   always_ff @(posedge clock_i or negedge rst_b_i) begin
      if (!rst_b_i) begin
         pin_meta <= '0;
         pin_sync <= '0;
      end else begin
         pin_meta <= {strap_level_i, hot_plug_input_i, ss_rate_i, lfps_i,
                      elec_idle_i, far_term_i, control_pin_zero_i, supply_ok_i};
         pin_sync <= pin_meta;
      end
   end

   wire supply_s = pin_sync[0];
   wire control_pin_zero_s   = pin_sync[1];
   wire far_s    = pin_sync[2];
   wire idle_s   = pin_sync[3];
   wire lfps_s   = pin_sync[4];
   wire ss_s     = pin_sync[5];
   wire hpd_s    = pin_sync[6];

   ////////////////////////////////////////////////////////////////////////
   // four-level strap decode; comparators give a thermometer code

   genvar g;
   for (g = 0; g < NUM_STRAPS; g++) begin : g_strap
      wire [2:0] th = pin_sync[7+3*g +: 3];
      assign strap_dec[2*g+1] = th[1];
      assign strap_dec[2*g]   = th[0] ^ th[1] ^ th[2];
   end

   ////////////////////////////////////////////////////////////////////////
   // internal reset and strap capture

   wire pwr_done = supply_s && !device_active_o
                   && (pwr_cnt == TIMER_W'(PWRUP_CYC - 1));

   always_ff @(posedge clock_i or negedge rst_b_i) begin
      if (!rst_b_i) begin
         pwr_cnt         <= '0;
         device_active_o <= 1'b0;
      end else if (!supply_s) begin
         pwr_cnt         <= '0;
         device_active_o <= 1'b0;
      end else if (pwr_done) begin
         device_active_o <= 1'b1;
      end else if (!device_active_o) begin
         pwr_cnt <= pwr_cnt + 1'b1;
      end
   end

   // straps are caught on the internal reset release edge, never later
   always_ff @(posedge clock_i or negedge rst_b_i) begin
      if (!rst_b_i) begin
         strap_code <= '0;
         reg_mode_o <= 1'b0;
      end else if (pwr_done) begin
         strap_code <= strap_dec;
         reg_mode_o <= (strap_dec[2*ST_IFSEL +: 2] != STRAP_PIN_MODE);
      end
   end

   // pulls stay on until the hold time has passed, to save power after
   always_ff @(posedge clock_i or negedge rst_b_i) begin
      if (!rst_b_i) begin
         hold_cnt        <= '0;
         strap_pull_en_o <= 1'b1;
      end else if (!supply_s) begin
         hold_cnt        <= '0;
         strap_pull_en_o <= 1'b1;
      end else if (device_active_o && strap_pull_en_o) begin
         if (hold_cnt == TIMER_W'(HOLD_CYC - 1)) begin
            strap_pull_en_o <= 1'b0;
         end else begin
            hold_cnt <= hold_cnt + 1'b1;
         end
      end
   end

   ////////////////////////////////////////////////////////////////////////
   // usb-only default and its exit pulse on control pin zero

   always_ff @(posedge clock_i or negedge rst_b_i) begin
      if (!rst_b_i) begin
         usb_only_o <= 1'b0;
         ctl_seq    <= 2'h0;
      end else if (pwr_done) begin
         usb_only_o <= 1'b1;
         ctl_seq    <= 2'h0;
      end else if (!device_active_o) begin
         usb_only_o <= 1'b0;
         ctl_seq    <= 2'h0;
      end else if (usb_only_o) begin
         if (ctl_seq == 2'h0 && !control_pin_zero_s) begin
            ctl_seq <= 2'h1;
         end else if (ctl_seq == 2'h1 && control_pin_zero_s) begin
            ctl_seq <= 2'h2;
         end else if (ctl_seq == 2'h2 && !control_pin_zero_s) begin
            usb_only_o <= 1'b0;
            ctl_seq    <= 2'h0;
         end
      end
   end

   ////////////////////////////////////////////////////////////////////////
   // link power state from line conditions; no traffic is decoded

   wire link_up = device_active_o && (usb_only_o || control_pin_zero_s);
   wire [EXIT_W-1:0] exit_tgt = (link_state_o == st_u1) ? EXIT_W'(U1_EXIT_CYC - 1)
                                                        : EXIT_W'(U23_EXIT_CYC - 1);

   always_ff @(posedge clock_i or negedge rst_b_i) begin
      if (!rst_b_i) begin
         link_state_o <= st_shut;
         link_cnt     <= '0;
         exit_cnt     <= '0;
         tx_idle_o    <= 1'b1;
         lfps_fwd_o   <= 1'b0;
         rx_detect_o  <= 1'b0;
         rx_term_en_o <= 1'b0;
      end else begin
         rx_detect_o <= 1'b0;
         if (!link_up) begin
            link_state_o <= st_shut;
            link_cnt     <= '0;
            exit_cnt     <= '0;
            tx_idle_o    <= 1'b1;
            lfps_fwd_o   <= 1'b0;
            rx_term_en_o <= 1'b0;
         end else if (link_state_o != st_shut && link_state_o != st_disc && !far_s) begin
            link_state_o <= st_disc;
            link_cnt     <= '0;
            exit_cnt     <= '0;
            tx_idle_o    <= 1'b1;
            lfps_fwd_o   <= 1'b0;
            rx_term_en_o <= 1'b0;
         end else begin
            case (link_state_o)
               st_shut: begin
                  if (link_cnt == TIMER_W'(SHTDN_CYC - 1)) begin
                     link_state_o <= st_u23;
                     rx_term_en_o <= far_s;
                     link_cnt     <= '0;
                  end else begin
                     link_cnt <= link_cnt + 1'b1;
                  end
               end
               st_disc: begin
                  if (far_s) begin
                     link_state_o <= st_u23;
                     rx_term_en_o <= 1'b1;
                     link_cnt     <= '0;
                  end else begin
                     rx_detect_o <= (link_cnt == '0);
                     if (link_cnt == TIMER_W'(RXDET_CYC - 1)) begin
                        link_cnt <= '0;
                     end else begin
                        link_cnt <= link_cnt + 1'b1;
                     end
                  end
               end
               st_u0: begin
                  if (!idle_s) begin
                     link_cnt <= '0;
                  end else if (link_cnt == TIMER_W'(IDLE_ENTRY_CYC - 1)) begin
                     tx_idle_o    <= 1'b1;
                     link_state_o <= st_u1;
                     link_cnt     <= '0;
                  end else begin
                     link_cnt <= link_cnt + 1'b1;
                  end
               end
               st_u1, st_u23: begin
                  if (ss_s && !idle_s) begin
                     link_state_o <= st_u0;
                     tx_idle_o    <= 1'b0;
                     lfps_fwd_o   <= 1'b0;
                     link_cnt     <= '0;
                     exit_cnt     <= '0;
                  end else if (idle_s) begin
                     tx_idle_o  <= 1'b1;
                     lfps_fwd_o <= 1'b0;
                     exit_cnt   <= '0;
                     // a long idle in U1 is taken as the deeper U2/U3
                     if (link_state_o == st_u1) begin
                        if (link_cnt == TIMER_W'(U1_U2_CYC - 1)) begin
                           link_state_o <= st_u23;
                           link_cnt     <= '0;
                        end else begin
                           link_cnt <= link_cnt + 1'b1;
                        end
                     end
                  end else begin
                     link_cnt <= '0;
                     if (!lfps_fwd_o) begin
                        if (exit_cnt == exit_tgt) begin
                           lfps_fwd_o <= 1'b1;
                           tx_idle_o  <= 1'b0;
                        end else begin
                           exit_cnt <= exit_cnt + 1'b1;
                        end
                     end
                  end
               end
               default: begin
                  link_state_o <= st_shut;
               end
            endcase
         end
      end
   end

   ////////////////////////////////////////////////////////////////////////
   // receiver equalization and gain selection

   always_ff @(posedge clock_i or negedge rst_b_i) begin
      if (!rst_b_i) begin
         eq_enable_o       <= 1'b0;
         usb_path_a_gain_o <= 4'h0;
         usb_path_b_gain_o <= 4'h0;
         video_gain_o      <= 4'h0;
      end else begin
         eq_enable_o <= !lfps_s;
         if (reg_mode_o) begin
            usb_path_a_gain_o <= gain_reg_a_i;
            usb_path_b_gain_o <= gain_reg_b_i;
            video_gain_o      <= gain_reg_video_i;
         end else begin
            usb_path_a_gain_o <= {strap_code[2*ST_UA1 +: 2], strap_code[2*ST_UA0 +: 2]};
            usb_path_b_gain_o <= {strap_code[2*ST_UB1 +: 2], strap_code[2*ST_UB0 +: 2]};
            video_gain_o      <= {strap_code[2*ST_V1 +: 2], strap_code[2*ST_V0 +: 2]};
         end
      end
   end

   ////////////////////////////////////////////////////////////////////////
   // aux snoop; works only without register mode's disable and in DP mode

   wire snoop_on = reg_mode_o && dp_mode_i && !snoop_dis;

   always_ff @(posedge clock_i or negedge rst_b_i) begin
      if (!rst_b_i) begin
         lane_cnt  <= LANE_RST;
         pwr_state <= PWR_RST;
      end else if (aux_wr_i && snoop_on) begin
         if (aux_addr_i == AUX_LANE_ADDR) begin
            lane_cnt <= aux_data_i[4:0];
         end
         if (aux_addr_i == AUX_PWR_ADDR) begin
            pwr_state <= aux_data_i[2:0];
         end
      end
   end

   for (g = 0; g < 4; g++) begin : g_lane
      always_ff @(posedge clock_i or negedge rst_b_i) begin
         if (!rst_b_i) begin
            dp_lane_en_o[g] <= 1'b0;
         end else if (!dp_mode_i) begin
            dp_lane_en_o[g] <= 1'b0;
         end else if (!reg_mode_o) begin
            dp_lane_en_o[g] <= hpd_s;
         end else if (snoop_dis) begin
            dp_lane_en_o[g] <= cfg_lane_en_i[g];
         end else if (pwr_state == PWR_D3) begin
            dp_lane_en_o[g] <= 1'b0;
         end else begin
            dp_lane_en_o[g] <= (lane_cnt > 5'(g));
         end
      end
   end

   ////////////////////////////////////////////////////////////////////////
   // register port

   always_ff @(posedge clock_i or negedge rst_b_i) begin
      if (!rst_b_i) begin
         snoop_dis <= SNOOP_DIS_RST;
      end else if (reg_wr_i && reg_addr_i == REG_SNOOP_CTRL) begin
         snoop_dis <= reg_wdata_i[SNOOP_DIS_BIT];
      end
   end

   always_comb begin
      next_rdata = 8'h00;
      if (reg_addr_i == REG_LINK_SNOOP) begin
         next_rdata[LANE_LSB +: 5] = lane_cnt;
         next_rdata[PWR_LSB +: 3]  = pwr_state;
      end else if (reg_addr_i == REG_SNOOP_CTRL) begin
         next_rdata[SNOOP_DIS_BIT]   = snoop_dis;
         next_rdata[SNOOP_ACT_BIT]   = snoop_on;
         next_rdata[LINK_ST_LSB +: 3] = link_state_o;
      end
   end

   always_ff @(posedge clock_i or negedge rst_b_i) begin
      if (!rst_b_i) begin
         reg_rdata_o <= 8'h00;
      end else begin
         reg_rdata_o <= next_rdata;
      end
   end

   ////////////////////////////////////////////////////////////////////////
   // checks

   logic [EXIT_W-1:0]  brk_len;
   logic [TIMER_W-1:0] since_det;

   always_ff @(posedge clock_i or negedge rst_b_i) begin
      if (!rst_b_i) begin
         brk_len   <= '0;
         since_det <= '0;
      end else begin
         brk_len   <= (link_state_o == st_u23 && !idle_s && !lfps_fwd_o) ? brk_len + 1'b1 : '0;
         since_det <= (rx_detect_o || link_state_o != st_disc) ? '0 : since_det + 1'b1;
      end
   end

   sequence s_idle_hold;
      (link_state_o == st_u0 && $rose(idle_s)) ##1 (idle_s && link_up && far_s) [*2];
   endsequence

   sequence s_u1_break;
      (link_state_o == st_u1 && $fell(idle_s) && !lfps_fwd_o)
      ##1 (!idle_s && !ss_s && link_up && far_s);
   endsequence

   idle_entry_a: assert property (
      s_idle_hold |-> !tx_idle_o ##1 (tx_idle_o && link_state_o == st_u1))
      else $error("idle entry delay wrong");

   u1_exit_a: assert property (
      s_u1_break |-> !lfps_fwd_o ##1 lfps_fwd_o)
      else $error("u1 lfps forward delay wrong");

   u23_exit_a: assert property (
      (link_state_o == st_u23 && $rose(lfps_fwd_o)) |-> brk_len == EXIT_W'(A_U23))
      else $error("u2u3 lfps forward delay wrong");

   rxdet_gap_a: assert property (
      link_state_o == st_disc |-> since_det < TIMER_W'(RXDET_CYC))
      else $error("receiver detection interval exceeded");

   shut_exit_a: assert property (
      (link_state_o == st_u23 && $past(link_state_o) == st_shut)
      |-> $past(link_cnt) == TIMER_W'(SHTDN_CYC - 1))
      else $error("shutdown exit time wrong");

   active_time_a: assert property (
      $rose(device_active_o) |-> $past(pwr_cnt) == TIMER_W'(PWRUP_CYC - 1) && $past(supply_s))
      else $error("device active at wrong time");

   lfps_eq_a: assert property (
      lfps_s |=> !eq_enable_o)
      else $error("equalizer left on during lfps");

   d3_lanes_a: assert property (
      (snoop_on && pwr_state == PWR_D3 && !aux_wr_i) |=> dp_lane_en_o == 4'h0)
      else $error("lanes active in d3");

   pin_lanes_a: assert property (
      (!reg_mode_o && dp_mode_i && hpd_s) |=> dp_lane_en_o == 4'hf)
      else $error("pin mode lanes not all on");

   strap_latch_a: assert property (
      $rose(device_active_o) |-> strap_code == $past(strap_dec) && strap_pull_en_o)
      else $error("straps not latched at reset release");

   usb_exit_a: assert property (
      $fell(usb_only_o) && device_active_o |-> $past(ctl_seq) == 2'h2 && !$past(control_pin_zero_s))
      else $error("usb-only left without pulse");

endmodule

`default_nettype wire

/* File: link_far_end.sv */
// far-end model: usb link partner line conditions and dp source aux writes
`timescale 1ns/1ps
`default_nettype none
module link_far_end (
   input  wire logic        clock_i,
   input  wire logic        rst_b_i,
   input  wire logic [1:0]  line_mode_i,
   input  wire logic        aux_go_i,
   input  wire logic [19:0] aux_addr_i,
   input  wire logic [7:0]  aux_data_i,
   output var  logic        far_term_o,
   output var  logic        elec_idle_o,
   output var  logic        lfps_o,
   output var  logic        ss_rate_o,
   output var  logic        aux_wr_o,
   output var  logic [19:0] aux_addr_o,
   output var  logic [7:0]  aux_data_o
);
   // modes: 0 detached, 1 idle, 2 superspeed traffic, 3 lfps burst
   always_ff @(posedge clock_i or negedge rst_b_i) begin
      if (!rst_b_i) begin
         {far_term_o, elec_idle_o, lfps_o, ss_rate_o} <= 4'h4;
      end else begin
         far_term_o  <= line_mode_i != 2'h0;
         elec_idle_o <= line_mode_i < 2'h2;
         ss_rate_o   <= line_mode_i == 2'h2;
         lfps_o      <= line_mode_i == 2'h3;
      end
   end
   // whole synced writes only; address and data toggle when no write is on
   always_ff @(posedge clock_i or negedge rst_b_i) begin
      if (!rst_b_i) begin
         {aux_wr_o, aux_addr_o, aux_data_o} <= '0;
      end else begin
         aux_wr_o   <= aux_go_i;
         aux_addr_o <= aux_go_i ? aux_addr_i : ~aux_addr_o;
         aux_data_o <= aux_go_i ? aux_data_i : ~aux_data_o;
      end
   end
endmodule
`default_nettype wire

/* File: typec_redriver_lane_control_bench.sv */
// self-checking bench for the redriver lane control
`timescale 1ns/1ps
`default_nettype none
module typec_redriver_lane_control_bench;
   import redriver_pkg::*;
   logic clock_i = 0, rst_b_i = 0, supply_ok_i = 0, dp_mode_i = 0, hpd = 0, aux_go = 0;
   logic reg_wr_i = 0, far_term, idle, lfps, ss, aux_wr, act, pull, rmode, uonly, txi, fwd;
   logic det, term, eqen, control_pin_zero = 0;
   logic [1:0] line_mode = 0;
   logic [19:0] aux_a = 0, aux_addr;
   logic [7:0] aux_d = 0, aux_data, reg_addr_i = 0, reg_wdata_i = 0, rdata, rd;
   logic [20:0] strap = {3'b011, 3'b001, {4{3'b111}}, 3'b111};
   logic [3:0] ga, gb, gv, lanes, cfg_l = 4'h5, g_a = 4'h6, g_b = 4'h7, g_v = 4'h8;
   link_state_t st;
   int err_count = 0, num_checks = 0, pulses;
   always #2 clock_i = ~clock_i;
   link_far_end far (.clock_i(clock_i), .rst_b_i(rst_b_i), .line_mode_i(line_mode),
      .aux_go_i(aux_go), .aux_addr_i(aux_a), .aux_data_i(aux_d), .far_term_o(far_term),
      .elec_idle_o(idle), .lfps_o(lfps), .ss_rate_o(ss), .aux_wr_o(aux_wr),
      .aux_addr_o(aux_addr), .aux_data_o(aux_data));
   typec_redriver_lane_control #(.RXDET_CYC(64), .SHTDN_CYC(40), .PWRUP_CYC(20),
      .HOLD_CYC(4), .U1_U2_CYC(32)) uut (.clock_i(clock_i), .rst_b_i(rst_b_i),
      .supply_ok_i(supply_ok_i), .control_pin_zero_i(control_pin_zero), .far_term_i(far_term),
      .elec_idle_i(idle), .lfps_i(lfps), .ss_rate_i(ss), .hot_plug_input_i(hpd),
      .strap_level_i(strap), .dp_mode_i(dp_mode_i), .cfg_lane_en_i(cfg_l),
      .gain_reg_a_i(g_a), .gain_reg_b_i(g_b), .gain_reg_video_i(g_v),
      .aux_wr_i(aux_wr), .aux_addr_i(aux_addr), .aux_data_i(aux_data), .reg_wr_i(reg_wr_i),
      .reg_addr_i(reg_addr_i), .reg_wdata_i(reg_wdata_i), .device_active_o(act),
      .strap_pull_en_o(pull), .reg_mode_o(rmode), .usb_only_o(uonly), .link_state_o(st),
      .tx_idle_o(txi), .lfps_fwd_o(fwd), .rx_detect_o(det), .rx_term_en_o(term),
      .eq_enable_o(eqen), .usb_path_a_gain_o(ga), .usb_path_b_gain_o(gb),
      .video_gain_o(gv), .dp_lane_en_o(lanes), .reg_rdata_o(rdata));
   ////////////////////////////////////////////////////////////////////////////////
   task test_done();
      $display("checks %0d mismatches %0d", num_checks, err_count);
      if (err_count == 0 && num_checks > 0) $display("TEST PASSED");
      else $display("TEST FAILED");
      $finish;
   endtask
   task tick(input int n);
      repeat (n) @(posedge clock_i);
      #1;
   endtask
   task check(input string what, input logic [7:0] exp, input logic [7:0] got);
      num_checks++;
      if (got !== exp) begin
         err_count++;
         $display("wrong value %s expected %h seen %h", what, exp, got);
      end
   endtask
   // sel 0 waits for active, 1 for lfps forwarding, 2 and up for state sel-2
   task wait_for(input int sel, input int lim);
      int k;
      k = 0;
      while (!(sel == 0 ? act === 1'b1 : sel == 1 ? fwd === 1'b1 :
               st === link_state_t'(sel - 2)) && k < lim) begin
         tick(1);
         k++;
      end
      if (k >= lim) begin
         check("wait", 8'(sel), 8'hff);
         test_done();
      end
   endtask
   task reg_read(input logic [7:0] a);
      reg_addr_i = a;
      tick(2);
      rd = rdata;
   endtask
   task reg_write(input logic [7:0] a, input logic [7:0] d);
      reg_wr_i = 1;
      reg_addr_i = a;
      reg_wdata_i = d;
      tick(1);
      reg_wr_i = 0;
   endtask
   task aux(input logic [19:0] a, input logic [7:0] d);
      aux_a = a;
      aux_d = d;
      aux_go = 1;
      tick(1);
      aux_go = 0;
      tick(4);
   endtask
   task power_up();
      rst_b_i = 0;
      supply_ok_i = 0;
      tick(6);
      rst_b_i = 1;
      supply_ok_i = 1;
      wait_for(0, 40);
      tick(8);
   endtask
   ////////////////////////////////////////////////////////////////////////////////
   initial begin
      tick(3);
      check("reset idle", 8'h07, {5'h0, txi, pull, 1'(st == st_shut)});
      power_up();
      check("usb only", 8'h01, {7'h0, uonly});
      check("pulls", 8'h00, {7'h0, pull});
      check("mode", 8'h01, {7'h0, rmode});
      check("gain", 8'h67, {ga, gb});
      $display("test power-up done");
      line_mode = 1;
      wait_for(2 + st_u23, 80);
      check("term", 8'h01, {7'h0, term});
      line_mode = 2;
      wait_for(2 + st_u0, 10);
      tick(1);
      check("tx idle", 8'h00, {7'h0, txi});
      line_mode = 1;
      wait_for(2 + st_u1, 10);
      check("tx idle", 8'h01, {7'h0, txi});
      line_mode = 3;
      wait_for(1, 10);
      tick(2);
      check("eq", 8'h00, {7'h0, eqen});
      line_mode = 2;
      wait_for(2 + st_u0, 10);
      tick(3);
      check("eq", 8'h01, {7'h0, eqen});
      line_mode = 0;
      wait_for(2 + st_disc, 10);
      pulses = 0;
      repeat (140) begin
         tick(1);
         pulses += int'(det === 1'b1);
      end
      check("detects", 8'h01, {7'h0, 1'(pulses == 2 || pulses == 3)});
      line_mode = 1;
      wait_for(2 + st_u23, 10);
      tick(1);
      check("term", 8'h01, {7'h0, term});
      line_mode = 3;
      tick(U23_EXIT_CYC - 10);
      check("fwd early", 8'h00, {7'h0, fwd});
      wait_for(1, 20);
      control_pin_zero = 1;
      tick(4);
      control_pin_zero = 0;
      tick(4);
      check("usb exit", 8'h01, {6'h0, uonly, 1'(st == st_shut)});
      control_pin_zero = 1;
      wait_for(2 + st_u23, 50);
      $display("test link done");
      dp_mode_i = 1;
      aux(20'h00101, 8'h02);
      check("lanes", 8'h03, {4'h0, lanes});
      aux(20'h00600, 8'h02);
      check("lanes", 8'h00, {4'h0, lanes});
      reg_read(8'h12);
      check("snoop reg", 8'h42, rd);
      reg_write(8'h13, 8'h01);
      tick(3);
      check("lanes", 8'h05, {4'h0, lanes});
      aux(20'h00101, 8'h04);
      reg_read(8'h12);
      check("snoop reg", 8'h42, rd);
      reg_read(8'h13);
      check("ctrl reg", 8'h01, rd & 8'h03);
      reg_read(8'h20);
      check("unmapped", 8'h00, rd);
      $display("test snoop done");
      strap[2:0] = 3'b000;
      power_up();
      hpd = 1;
      tick(5);
      check("mode", 8'h00, {7'h0, rmode});
      check("lanes", 8'h0f, {4'h0, lanes});
      check("video gain", 8'h09, {4'h0, gv});
      $display("test pin mode done");
      test_done();
   end
endmodule
`default_nettype wire
